// ===== src/dkp_consts.svh
// Constants of the drive keypad front-panel controller.
// Assumes a 20 MHz system clock and a synchronous active-high reset.
//
// Notes on behaviour
// [R1] Program key toggles normal and programming mode
// [R2] Program key clears a latched fault, resets drive
// [R3] Function key steps setpoint, output, current views
// [R4] Function shows parameter value, second press stores
// [R5] Direction key ramps to zero, then reverses
// [R6] Direction from terminals when command source 1/2
// [R7] Inch key runs drive at inch frequency
// [R8] Run key starts; ignored under terminal control
// [R9] Up/down step once, auto-repeat when held
// [R10] Views tagged setpoint, output, custom, tally
// [R11] End acknowledgement shown about one second
// [R12] Factory defaults run at 60 Hz until stop
// [R13] Setpoint adjustable while stopped or running
// [R14] Running: only listed parameters writable, all readable
// [R15] Frequency source: keypad, analog sum, serial
// [R16] Command source: keypad, terminals, serial
// [R17] Wiring: two-wire pair, two-wire dir, three-wire
// [R18] Closed direction contact reverses, open stop stops
// [R19] Stop method: ramp to minimum, or coast
// [R20] Keys synchronised, debounced; repeat timing constants
`ifndef DKP_CONSTS_SVH
`define DKP_CONSTS_SVH
// Timing: base tick and derived millisecond counts
`define DKP_CLK_MHZ 20
`define DKP_TICK_US 1000
`define DKP_DEBOUNCE_MS 8
`define DKP_RPT_DELAY_MS 500
`define DKP_RPT_RATE_MS 100
`define DKP_END_MS 1000
// Register offsets (byte addresses)
`define DKP_OFS_CFG 8'h00
`define DKP_OFS_INCH 8'h04
`define DKP_OFS_SCALE 8'h08
`define DKP_OFS_MINF 8'h0c
`define DKP_OFS_MAXF 8'h10
`define DKP_OFS_SETP 8'h14
`define DKP_OFS_STAT 8'h18
// Configuration field positions
`define DKP_CFG_FSRC_LSB 0
`define DKP_CFG_CSRC_LSB 2
`define DKP_CFG_WIRE_LSB 5
`define DKP_CFG_STOP_BIT 7
// Reset values (frequencies in 0.1 Hz)
`define DKP_RST_SETP 16'h0258
`define DKP_RST_INCH 16'h003c
`define DKP_RST_SCALE 16'h0001
`define DKP_RST_MINF 16'h000f
`define DKP_RST_MAXF 16'h0258
// Parameter numbers mirrored in local configuration
`define DKP_PN_FSRC 8'h00
`define DKP_PN_CSRC 8'h01
`define DKP_PN_STOP 8'h02
`define DKP_PN_MAXF 8'h03
`define DKP_PN_MINF 8'h08
`define DKP_PN_INCH 8'h17
`define DKP_PN_WIRE 8'h26
`define DKP_PN_SCALE 8'h41
`define DKP_PN_LAST 8'h45
`endif

// ===== src/dkp_pkg.sv
// Types of the drive keypad front-panel controller.
// Assumes dkp_consts.svh supplies the numeric constants.
package dkp_pkg;
	// Key positions on the keys input
	typedef enum logic [2:0] {
		KEY_PROG, KEY_FUNC, KEY_DIR, KEY_INCH,
		KEY_RUN, KEY_STOP, KEY_UP, KEY_DOWN
	} dkp_key_t;
	// Shown quantity, tagged by prefix on the panel
	typedef enum logic [2:0] {
		VIEW_SETP, VIEW_OUTF, VIEW_CUST, VIEW_TALLY,
		VIEW_CURR, VIEW_PNUM, VIEW_PVAL, VIEW_END
	} dkp_view_t;
	// Panel mode
	typedef enum logic [1:0] {
		PM_NORMAL, PM_SELECT, PM_EDIT, PM_END
	} dkp_pmode_t;
	// Drive sequencing state
	typedef enum logic [1:0] {
		DR_IDLE, DR_RUN, DR_STOPRAMP
	} dkp_drv_t;
	// Display word to the panel
	typedef struct packed {
		dkp_view_t view;
		logic [31:0] value;
	} dkp_disp_t;
	// Parameter store write
	typedef struct packed {
		logic [7:0] num;
		logic [15:0] value;
	} dkp_pwr_t;
endpackage : dkp_pkg

// ===== src/dkp_panel.sv
// Keypad, display and run/direction sequencing of the drive panel.
// Assumes inputs synchronous to ref_clk_i; store answers reads at once.
//
// Added by the designer: the register offsets and the plain strobed port.
`include "dkp_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module dkp_panel
	import dkp_pkg::*;
#(
	parameter int TICK_CYC = `DKP_TICK_US * `DKP_CLK_MHZ
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// Keys, one bit per key, high while pressed
	input wire logic [7:0] keys_i,
	// Terminal contacts, high while closed
	input wire logic term_fwd_i,
	input wire logic term_rev_i,
	input wire logic term_stop_i,
	// Frequency sources in 0.1 Hz
	input wire logic [15:0] avi_freq_i,
	input wire logic [15:0] aci_freq_i,
	input wire logic [15:0] serial_freq_i,
	input wire logic serial_run_i,
	input wire logic serial_rev_i,
	// Drive status
	input wire logic fault_i,
	input wire logic [15:0] out_current_i,
	input wire logic [15:0] tally_i,
	// Parameter store
	output logic [7:0] param_rd_num_o,
	input wire logic [15:0] param_rd_data_i,
	output dkp_pwr_t param_wr_o,
	output logic param_wr_en_o,
	output logic param_rejected_o,
	// Drive control
	output logic drive_on_o,
	output logic reverse_o,
	output logic [15:0] out_freq_o,
	output logic fault_reset_o,
	// Display
	output dkp_disp_t disp_o
);
	localparam int TICK_W = $clog2(TICK_CYC + 1);
	localparam logic [3:0] DEB_TICKS = 4'(`DKP_DEBOUNCE_MS);
	localparam logic [9:0] RPT_DELAY = 10'(`DKP_RPT_DELAY_MS);
	localparam logic [9:0] RPT_RATE = 10'(`DKP_RPT_RATE_MS);
	localparam logic [9:0] END_TICKS = 10'(`DKP_END_MS);

	logic [TICK_W-1:0] tick_cnt_reg; // Millisecond divider
	logic tick; // One-cycle millisecond enable
	wire logic [7:0] key_press; // Debounced press pulses
	wire logic [7:0] key_rpt, key_held, key_rel; // Repeat, held, release
	logic step_up, step_dn; // Up/down with repeat
	// Configuration
	logic [1:0] fsrc_reg;
	logic [2:0] csrc_reg;
	logic [1:0] wire_reg;
	logic stop_coast_reg;
	logic [15:0] inch_reg, scale_reg, minf_reg, maxf_reg, setp_reg;
	// Panel state
	dkp_pmode_t pmode_reg;
	dkp_view_t view_reg;
	logic [7:0] pnum_reg;
	logic [15:0] pval_reg;
	logic [9:0] end_cnt_reg;
	logic fault_reg;
	// Drive state
	dkp_drv_t drv_reg;
	logic dir_cmd_reg; // Wanted direction, 1 is reverse
	logic rev_reg; // Direction being driven
	logic [15:0] freq_reg;
	logic run3_reg; // Three-wire run latch
	logic kp_stop_reg; // Keypad stop held over terminal run
	logic fwd_prev_reg;
	// Derived
	logic term_mode, serial_mode, kp_mode, kp_stop_ok;
	logic [16:0] ana_sum;
	logic [15:0] src_freq, target;
	logic term_run, term_rev, ext_run, ext_rev;
	logic commit, writable;

	// Millisecond enable from the system clock
	always_ff @(posedge ref_clk_i) begin
		if (reset_i || tick_cnt_reg == TICK_W'(TICK_CYC - 1)) begin
			tick_cnt_reg <= '0;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 1'b1;
		end
	end
	assign tick = (tick_cnt_reg == TICK_W'(TICK_CYC - 1));

	// Per-key synchroniser, debounce and auto-repeat
	for (genvar gk = 0; gk < 8; gk++) begin : g_key
		logic s1_reg, s2_reg, stable_reg;
		logic [3:0] deb_reg;
		logic [9:0] hold_reg;
		logic settle;
		assign settle = tick && (s2_reg != stable_reg) &&
			(deb_reg == DEB_TICKS - 4'h1);
		// Two-flop synchroniser, then tick-based settle counter
		always_ff @(posedge ref_clk_i) begin
			s1_reg <= keys_i[gk]; // [R20]
			s2_reg <= s1_reg;
			if (reset_i) begin
				stable_reg <= 1'b0;
				deb_reg <= 4'h0;
			end else if (s2_reg == stable_reg) begin
				deb_reg <= 4'h0;
			end else if (settle) begin
				stable_reg <= s2_reg; // [R20]
				deb_reg <= 4'h0;
			end else if (tick) begin
				deb_reg <= deb_reg + 4'h1;
			end
		end
		// Hold timer: first repeat after delay, then at rate
		always_ff @(posedge ref_clk_i) begin
			if (reset_i || !stable_reg) begin
				hold_reg <= 10'h000;
			end else if (tick && hold_reg == RPT_DELAY) begin
				hold_reg <= RPT_DELAY - RPT_RATE; // [R9]
			end else if (tick) begin
				hold_reg <= hold_reg + 10'h001;
			end
		end
		assign key_press[gk] = settle && s2_reg;
		assign key_rpt[gk] = tick && stable_reg && hold_reg == RPT_DELAY;
		assign key_held[gk] = stable_reg;
		assign key_rel[gk] = settle && !s2_reg;
	end

	assign step_up = key_press[KEY_UP] | key_rpt[KEY_UP]; // [R9]
	assign step_dn = key_press[KEY_DOWN] | key_rpt[KEY_DOWN]; // [R9]

	// Source decoding
	assign term_mode = (csrc_reg == 3'h1) || (csrc_reg == 3'h2); // [R16]
	assign serial_mode = (csrc_reg == 3'h3) || (csrc_reg == 3'h4);
	assign kp_mode = !term_mode && !serial_mode;
	assign kp_stop_ok = kp_mode || csrc_reg == 3'h1 || csrc_reg == 3'h3;
	assign ana_sum = {1'b0, avi_freq_i} + {1'b0, aci_freq_i};

	// Setpoint from the selected frequency source, analog sum clamped to maximum
	always_comb begin
		unique case (fsrc_reg)
			2'h1: src_freq = (ana_sum > {1'b0, maxf_reg}) ? maxf_reg :
				ana_sum[15:0]; // [R15]
			2'h2: src_freq = serial_freq_i; // [R15]
			default: src_freq = setp_reg; // [R15]
		endcase
	end

	// Terminal decoding per wiring style
	always_comb begin
		unique case (wire_reg)
			2'h1: begin
				term_run = term_fwd_i; // [R17]
				term_rev = term_rev_i; // [R18]
			end
			2'h2: begin
				term_run = run3_reg && term_stop_i; // [R18]
				term_rev = term_rev_i; // [R18]
			end
			default: begin
				term_run = term_fwd_i ^ term_rev_i; // [R17]
				term_rev = term_rev_i;
			end
		endcase
		ext_run = term_mode ? term_run : serial_run_i;
		ext_rev = term_mode ? term_rev : serial_rev_i; // [R6]
	end

	// Three-wire latch: momentary run closes it, open stop drops it
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			run3_reg <= 1'b0;
			fwd_prev_reg <= 1'b0;
		end else begin
			fwd_prev_reg <= term_fwd_i;
			if (!term_stop_i) begin
				run3_reg <= 1'b0; // [R18]
			end else if (term_fwd_i && !fwd_prev_reg) begin
				run3_reg <= 1'b1; // [R17]
			end
		end
	end

	// Parameters that stay writable while the drive runs
	always_comb begin
		writable = (drv_reg == DR_IDLE) ||
			(pnum_reg >= 8'h0a && pnum_reg <= 8'h0e) ||
			(pnum_reg >= 8'h10 && pnum_reg <= 8'h17) ||
			(pnum_reg == 8'h2c) ||
			(pnum_reg >= 8'h30 && pnum_reg <= 8'h32) ||
			(pnum_reg >= 8'h34 && pnum_reg <= 8'h37) ||
			(pnum_reg == 8'h41); // [R14]
	end
	assign commit = (pmode_reg == PM_EDIT) && key_press[KEY_FUNC] &&
		!key_press[KEY_PROG];

	// Panel mode machine
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			pmode_reg <= PM_NORMAL;
			end_cnt_reg <= 10'h000;
		end else if (key_press[KEY_PROG] && !fault_reg) begin
			pmode_reg <= (pmode_reg == PM_NORMAL) ? PM_SELECT :
				PM_NORMAL; // [R1]
		end else begin
			unique case (pmode_reg)
				PM_NORMAL: ;
				PM_SELECT: if (key_press[KEY_FUNC]) begin
					pmode_reg <= PM_EDIT; // [R4]
				end
				PM_EDIT: if (commit) begin
					pmode_reg <= writable ? PM_END : PM_SELECT; // [R14]
					end_cnt_reg <= 10'h000;
				end
				PM_END: if (tick) begin
					if (end_cnt_reg == END_TICKS - 10'h001) begin
						pmode_reg <= PM_SELECT; // [R11]
					end else begin
						end_cnt_reg <= end_cnt_reg + 10'h001;
					end
				end
			endcase
		end
	end

	// Parameter number and edit value
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			pnum_reg <= 8'h00;
			pval_reg <= 16'h0000;
		end else if (pmode_reg == PM_SELECT) begin
			if (key_press[KEY_FUNC]) begin
				pval_reg <= param_rd_data_i; // [R4]
			end else if (step_up) begin
				pnum_reg <= (pnum_reg == `DKP_PN_LAST) ? 8'h00 :
					pnum_reg + 8'h01; // [R9]
			end else if (step_dn) begin
				pnum_reg <= (pnum_reg == 8'h00) ? `DKP_PN_LAST :
					pnum_reg - 8'h01; // [R9]
			end
		end else if (pmode_reg == PM_EDIT) begin
			if (step_up && pval_reg != 16'hffff) begin
				pval_reg <= pval_reg + 16'h0001; // [R9]
			end else if (step_dn && pval_reg != 16'h0000) begin
				pval_reg <= pval_reg - 16'h0001; // [R9]
			end
		end
	end
	assign param_rd_num_o = pnum_reg; // [R14]

	// Store write pulse and refusal pulse
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			param_wr_en_o <= 1'b0;
			param_rejected_o <= 1'b0;
			param_wr_o <= '0;
		end else begin
			param_wr_en_o <= commit && writable; // [R4]
			param_rejected_o <= commit && !writable; // [R14]
			if (commit) begin
				param_wr_o <= '{num: pnum_reg, value: pval_reg};
			end
		end
	end

	// Configuration: register port, else keypad commits
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			fsrc_reg <= 2'h0;
			csrc_reg <= 3'h0;
			wire_reg <= 2'h0;
			stop_coast_reg <= 1'b0;
			inch_reg <= `DKP_RST_INCH;
			scale_reg <= `DKP_RST_SCALE;
			minf_reg <= `DKP_RST_MINF;
			maxf_reg <= `DKP_RST_MAXF;
		end else if (reg_wr_i) begin
			unique case (reg_addr_i)
				`DKP_OFS_CFG: begin
					fsrc_reg <= reg_wdata_i[`DKP_CFG_FSRC_LSB +: 2];
					csrc_reg <= reg_wdata_i[`DKP_CFG_CSRC_LSB +: 3];
					wire_reg <= reg_wdata_i[`DKP_CFG_WIRE_LSB +: 2];
					stop_coast_reg <= reg_wdata_i[`DKP_CFG_STOP_BIT];
				end
				`DKP_OFS_INCH: inch_reg <= reg_wdata_i[15:0];
				`DKP_OFS_SCALE: scale_reg <= reg_wdata_i[15:0];
				`DKP_OFS_MINF: minf_reg <= reg_wdata_i[15:0];
				`DKP_OFS_MAXF: maxf_reg <= reg_wdata_i[15:0];
				default: ;
			endcase
		end else if (commit && writable) begin
			unique case (pnum_reg)
				`DKP_PN_FSRC: fsrc_reg <= pval_reg[1:0]; // [R15]
				`DKP_PN_CSRC: csrc_reg <= pval_reg[2:0]; // [R16]
				`DKP_PN_STOP: stop_coast_reg <= pval_reg[0]; // [R19]
				`DKP_PN_WIRE: wire_reg <= pval_reg[1:0]; // [R17]
				`DKP_PN_INCH: inch_reg <= pval_reg;
				`DKP_PN_SCALE: scale_reg <= pval_reg;
				`DKP_PN_MINF: minf_reg <= pval_reg;
				`DKP_PN_MAXF: maxf_reg <= pval_reg;
				default: ;
			endcase
		end
	end

	// Keypad setpoint: port write, or up/down on its view
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			setp_reg <= `DKP_RST_SETP; // [R12]
		end else if (reg_wr_i && reg_addr_i == `DKP_OFS_SETP) begin
			setp_reg <= reg_wdata_i[15:0];
		end else if (pmode_reg == PM_NORMAL && view_reg == VIEW_SETP &&
			fsrc_reg == 2'h0) begin
			if (step_up && setp_reg < maxf_reg) begin
				setp_reg <= setp_reg + 16'h0001; // [R13]
			end else if (step_dn && setp_reg != 16'h0000) begin
				setp_reg <= setp_reg - 16'h0001; // [R13]
			end
		end
	end

	// Normal-mode view selection
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			view_reg <= VIEW_SETP;
		end else if (pmode_reg == PM_NORMAL) begin
			if (key_press[KEY_FUNC]) begin
				unique case (view_reg)
					VIEW_SETP: view_reg <= VIEW_OUTF; // [R3]
					VIEW_OUTF: view_reg <= VIEW_CURR; // [R3]
					default: view_reg <= VIEW_SETP; // [R3]
				endcase
			end else if (view_reg != VIEW_SETP || fsrc_reg != 2'h0) begin
				if (step_up) begin
					view_reg <= (view_reg == VIEW_CURR) ? VIEW_SETP :
						dkp_view_t'(view_reg + 3'h1); // [R9]
				end else if (step_dn) begin
					view_reg <= (view_reg == VIEW_SETP) ? VIEW_CURR :
						dkp_view_t'(view_reg - 3'h1); // [R9]
				end
			end
		end
	end

	// Display word, registered
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			disp_o <= '{view: VIEW_SETP, value: 32'h0};
		end else begin
			unique case (pmode_reg)
				PM_SELECT: disp_o <= '{view: VIEW_PNUM,
					value: {24'h0, pnum_reg}};
				PM_EDIT: disp_o <= '{view: VIEW_PVAL,
					value: {16'h0, pval_reg}};
				PM_END: disp_o <= '{view: VIEW_END, value: 32'h0}; // [R11]
				PM_NORMAL: begin
					disp_o.view <= view_reg; // [R10]
					unique case (view_reg)
						VIEW_SETP: disp_o.value <= {16'h0, src_freq};
						VIEW_OUTF: disp_o.value <= {16'h0, freq_reg};
						VIEW_CUST: disp_o.value <= 32'(freq_reg) * 32'(scale_reg);
						VIEW_TALLY: disp_o.value <= {16'h0, tally_i};
						default: disp_o.value <= {16'h0, out_current_i};
					endcase
				end
			endcase
		end
	end

	// Fault latch and reset pulse
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			fault_reg <= 1'b0;
			fault_reset_o <= 1'b0;
		end else begin
			fault_reset_o <= fault_reg && key_press[KEY_PROG]; // [R2]
			if (fault_i) begin
				fault_reg <= 1'b1; // Set wins over clear
			end else if (key_press[KEY_PROG]) begin
				fault_reg <= 1'b0; // [R2]
			end
		end
	end

	// Keypad stop holds off a terminal or serial run under command source 1 or 3 until it drops
	always_ff @(posedge ref_clk_i) begin
		if (reset_i || !ext_run) begin
			kp_stop_reg <= 1'b0;
		end else if (key_press[KEY_STOP] && kp_stop_ok) begin
			kp_stop_reg <= 1'b1; // [R16]
		end
	end

	// Ramp target: zero while a reversal is pending
	always_comb begin
		if (dir_cmd_reg != rev_reg) begin
			target = 16'h0000; // [R5]
		end else if (drv_reg == DR_STOPRAMP) begin
			target = minf_reg; // [R19]
		end else if (kp_mode && key_held[KEY_INCH]) begin
			target = inch_reg; // [R7]
		end else begin
			target = src_freq;
		end
	end

	// Run/stop sequencing
	always_ff @(posedge ref_clk_i) begin
		if (reset_i || fault_reg) begin
			drv_reg <= DR_IDLE;
		end else begin
			unique case (drv_reg)
				DR_IDLE: if (kp_mode ? (key_press[KEY_RUN] ||
					key_press[KEY_INCH]) : (ext_run && !kp_stop_reg)) begin
					drv_reg <= DR_RUN; // [R8]
				end
				DR_RUN: if ((kp_mode && (key_press[KEY_STOP] ||
					key_rel[KEY_INCH])) ||
					(!kp_mode && (!ext_run || kp_stop_reg ||
					(key_press[KEY_STOP] && kp_stop_ok)))) begin
					drv_reg <= stop_coast_reg ? DR_IDLE :
						DR_STOPRAMP; // [R19]
				end
				DR_STOPRAMP: if (freq_reg <= minf_reg) begin
					drv_reg <= DR_IDLE; // [R19]
				end
			endcase
		end
	end

	// Wanted direction: keypad toggle, or external source
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			dir_cmd_reg <= 1'b0;
		end else if (!kp_mode && csrc_reg != 3'h3 && csrc_reg != 3'h4) begin
			dir_cmd_reg <= ext_rev; // [R6]
		end else if (serial_mode) begin
			dir_cmd_reg <= serial_rev_i;
		end else if (key_press[KEY_DIR]) begin
			dir_cmd_reg <= !dir_cmd_reg; // [R5]
		end
	end

	// Output frequency ramp, one 0.1 Hz step per tick
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			freq_reg <= 16'h0000;
			rev_reg <= 1'b0;
		end else if (drv_reg == DR_IDLE) begin
			freq_reg <= 16'h0000; // [R19]
			rev_reg <= dir_cmd_reg;
		end else if (freq_reg == 16'h0000 && dir_cmd_reg != rev_reg) begin
			rev_reg <= dir_cmd_reg; // [R5]
		end else if (tick) begin
			if (freq_reg < target) begin
				freq_reg <= freq_reg + 16'h0001;
			end else if (freq_reg > target) begin
				freq_reg <= freq_reg - 16'h0001; // [R5]
			end
		end
	end
	assign out_freq_o = freq_reg;
	assign reverse_o = rev_reg;
	assign drive_on_o = (drv_reg != DR_IDLE);

	// Register reads, answer one cycle after the strobe
	always_ff @(posedge ref_clk_i) begin
		if (reset_i || !reg_rd_i) begin
			reg_rdata_o <= 32'h0;
		end else begin
			unique case (reg_addr_i)
				`DKP_OFS_CFG: reg_rdata_o <= {24'h0, stop_coast_reg,
					wire_reg, csrc_reg, fsrc_reg};
				`DKP_OFS_INCH: reg_rdata_o <= {16'h0, inch_reg};
				`DKP_OFS_SCALE: reg_rdata_o <= {16'h0, scale_reg};
				`DKP_OFS_MINF: reg_rdata_o <= {16'h0, minf_reg};
				`DKP_OFS_MAXF: reg_rdata_o <= {16'h0, maxf_reg};
				`DKP_OFS_SETP: reg_rdata_o <= {16'h0, setp_reg};
				`DKP_OFS_STAT: reg_rdata_o <= {freq_reg, 10'h0,
					pmode_reg, fault_reg, rev_reg, dir_cmd_reg,
					drive_on_o};
				default: reg_rdata_o <= 32'h0;
			endcase
		end
	end
endmodule : dkp_panel
`default_nettype wire

// ===== dv/dkp_panel_assertions.sv
// Checker of the panel's port timing.
// Assumes it is bound onto dkp_panel, one clock.
`timescale 1ns/1ns
`default_nettype none
module dkp_panel_assertions
	import dkp_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Watched outputs
	input wire logic param_wr_en_o,
	input wire logic param_rejected_o,
	input wire logic drive_on_o,
	input wire logic reverse_o,
	input wire logic [15:0] out_freq_o,
	input wire logic fault_reset_o,
	input wire dkp_disp_t disp_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	// End acknowledgement on show
	sequence end_on;
		disp_o.view == VIEW_END;
	endsequence
	// Commit shows the end screen
	commit_end_a: assert property (param_wr_en_o |-> ##[0:1] end_on)
		else $error("commit without end screen");
	// End screen stands a while
	end_hold_a: assert property ($rose(disp_o.view == VIEW_END)
		|-> end_on [*8])
		else $error("end screen too short");
	// End screen returns to number view
	end_leave_a: assert property ($fell(disp_o.view == VIEW_END)
		|-> disp_o.view == VIEW_PNUM)
		else $error("end screen left wrongly");
	// Store write is one pulse
	wr_pulse_a: assert property (param_wr_en_o |=> !param_wr_en_o)
		else $error("store write too long");
	// Refusal only while running, never with a write
	reject_run_a: assert property (param_rejected_o
		|-> drive_on_o && !param_wr_en_o ##1 !param_wr_en_o)
		else $error("bad refusal");
	// Fault clear is one pulse
	fault_pulse_a: assert property (fault_reset_o |=> !fault_reset_o)
		else $error("fault clear too long");
	// Running output moves at most one step
	freq_ramp_a: assert property (drive_on_o && $past(drive_on_o)
		|-> out_freq_o - $past(out_freq_o) inside {16'h0, 16'h1, 16'hffff})
		else $error("output jumped");
	// Reversal only near standstill
	rev_zero_a: assert property (drive_on_o && $past(drive_on_o)
		&& $changed(reverse_o) |-> out_freq_o <= 16'h1)
		else $error("reversed while turning");
endmodule // dkp_panel_assertions
bind dkp_panel dkp_panel_assertions u_chk (.ref_clk_i, .reset_i,
	.param_wr_en_o, .param_rejected_o, .drive_on_o, .reverse_o,
	.out_freq_o, .fault_reset_o, .disp_o);
`default_nettype wire

// ===== dv/dkp_keypad_model.sv
// Operator keypad with contact bounce, and the parameter store.
// Assumes press requests of one cycle, taken only while idle.
`timescale 1ns/1ns
`default_nettype none
module dkp_keypad_model
	import dkp_pkg::*;
#(
	parameter int TICK_CYC = 4
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Press request from the bench
	input wire logic press_i,
	input wire dkp_key_t key_i,
	input wire logic [15:0] hold_i,
	output logic busy_o,
	// Key contacts, pulled low when open
	output logic [7:0] keys_o,
	// Store lookup
	input wire logic [7:0] param_rd_num_i,
	output logic [15:0] param_rd_data_o
);
	int cnt; // Cycles into the press
	int len; // Held cycles
	dkp_key_t key; // Key in use
	// Store answers at once; value marks the number
	assign param_rd_data_o = {8'h01, param_rd_num_i};
	// Hold, then stay released 12 ticks
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			busy_o <= 1'b0;
			cnt <= 0;
		end else if (press_i && !busy_o) begin
			busy_o <= 1'b1;
			cnt <= 0;
			len <= int'(hold_i) * TICK_CYC;
			key <= key_i;
		end else if (busy_o) begin
			cnt <= cnt + 1;
			if (cnt >= len + 12 * TICK_CYC)
				busy_o <= 1'b0;
		end
	end
	// Contact chatters for six cycles at make
	always_comb begin
		keys_o = 8'h0;
		if (busy_o && cnt < len)
			keys_o[key] = (cnt > 5) || cnt[0];
	end
endmodule // dkp_keypad_model
`default_nettype wire

// ===== dv/drive_keypad_front_panel_control_tb.sv
// Self-checking bench of the drive panel.
// Assumes the keypad model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module drive_keypad_front_panel_control_tb;
	import dkp_pkg::*;
	localparam int TC = 4; // Short tick
	// Stimulus
	logic ref_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [7:0] reg_addr_i = 8'h0;
	logic [31:0] reg_wdata_i = 32'h0;
	logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, press = 1'b0, term_stop_i = 1'b1;
	logic term_fwd_i = 1'b0, term_rev_i = 1'b0, fault_i = 1'b0;
	logic [15:0] avi = 16'h0, aci = 16'h0, hold = 16'h0, tally = 16'h0;
	dkp_key_t key = KEY_PROG;
	// Observed
	logic [31:0] reg_rdata_o, q;
	logic [7:0] keys_i, pnum;
	logic [15:0] pdata, out_freq_o;
	logic busy, drive_on_o, reverse_o, wr_en, rej, frst;
	dkp_pwr_t param_wr_o;
	dkp_disp_t disp_o;
	int num_errors = 0, n_tests = 0, cyc = 0, k, n_wr = 0, n_rej = 0, n_fr = 0;
	// Reset values at the register map
	localparam logic [7:0] RA [7] = '{8'h00, 8'h04, 8'h08, 8'h0c,
		8'h10, 8'h14, 8'h1c};
	localparam logic [31:0] RV [7] = '{32'h0, 32'h3c, 32'h1, 32'hf,
		32'h258, 32'h258, 32'h0};
	dkp_panel #(.TICK_CYC(TC)) dut (.ref_clk_i, .reset_i, .reg_addr_i,
		.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .keys_i, .term_fwd_i,
		.term_rev_i, .term_stop_i, .avi_freq_i(avi), .aci_freq_i(aci),
		.serial_freq_i(16'h0), .serial_run_i(1'b0), .serial_rev_i(1'b0),
		.fault_i, .out_current_i(16'h7), .tally_i(tally),
		.param_rd_num_o(pnum), .param_rd_data_i(pdata), .param_wr_o,
		.param_wr_en_o(wr_en), .param_rejected_o(rej), .drive_on_o,
		.reverse_o, .out_freq_o, .fault_reset_o(frst), .disp_o);
	dkp_keypad_model #(.TICK_CYC(TC)) u_pad (.ref_clk_i, .reset_i,
		.press_i(press), .key_i(key), .hold_i(hold), .busy_o(busy),
		.keys_o(keys_i), .param_rd_num_i(pnum), .param_rd_data_o(pdata));
	// Clock, 50 ns period
	always #25 ref_clk_i = ~ref_clk_i;
	// Pulse tallies and hang guard
	always @(posedge ref_clk_i) begin
		tally <= tally + 16'h1;
		cyc <= cyc + 1;
		n_wr <= n_wr + (wr_en === 1'b1);
		n_rej <= n_rej + (rej === 1'b1);
		n_fr <= n_fr + (frst === 1'b1);
		if (cyc == 80000) begin
			num_errors++;
			end_of_test();
		end
	end
	// Compare and report
	task automatic chk(input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %0t got %h want %h", $time, got, exp);
		end
	endtask
	// One-cycle register write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	// Read; data stands in the following cycle
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		#1 q = reg_rdata_o;
	endtask
	// Start a press of h ticks
	task automatic go(input dkp_key_t kk, input int h);
		@(posedge ref_clk_i);
		press <= 1'b1;
		key <= kk;
		hold <= 16'(h);
		@(posedge ref_clk_i);
		press <= 1'b0;
		#1;
	endtask
	// Wait n cycles, then settle
	task automatic cycles(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	// Press and wait for release
	task automatic tap(input dkp_key_t kk, input int h);
		go(kk, h);
		for (k = 0; k < 9000 && busy; k++) cycles(1);
	endtask
	// Wait until the output reaches f
	task automatic reach(input logic [15:0] f);
		for (k = 0; k < 3000 && out_freq_o !== f; k++) cycles(1);
		chk(out_freq_o, f);
	endtask
	// Wait until the drive is off
	task automatic halt();
		for (k = 0; k < 3000 && drive_on_o !== 1'b0; k++) cycles(1);
		chk(drive_on_o, 1'b0);
	endtask
	// Verdict
	task automatic end_of_test();
		$display("Checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (8) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			rd(RA[i]);
			chk(q, RV[i]);
		end
		wr(8'h18, 32'hffffffff);
		rd(8'h18);
		chk(q, 32'h0);
		$display("Test reset values done");
		tap(KEY_RUN, 12);
		reach(16'h258);
		wr(8'h14, 32'h1f4);
		reach(16'h1f4);
		tap(KEY_PROG, 12);
		tap(KEY_FUNC, 12);
		tap(KEY_FUNC, 12);
		chk(n_rej, 1);
		chk(n_wr, 0);
		tap(KEY_PROG, 12);
		tap(KEY_DIR, 12);
		for (k = 0; k < 3000 && reverse_o !== 1'b1; k++) cycles(1);
		chk(reverse_o, 1'b1);
		reach(16'h1f4);
		tap(KEY_STOP, 12);
		halt();
		$display("Test run, direction and refusal done");
		tap(KEY_PROG, 12);
		chk(disp_o.view, VIEW_PNUM);
		tap(KEY_FUNC, 12);
		chk(disp_o.view, VIEW_PVAL);
		chk(disp_o.value, 32'h100);
		tap(KEY_FUNC, 12);
		chk(n_wr, 1);
		chk(param_wr_o, 24'h100);
		chk(disp_o.view, VIEW_END);
		for (k = 0; k < 5000 && disp_o.view === VIEW_END; k++) cycles(1);
		chk(k > 3500 && k < 4100, 1'b1);
		tap(KEY_PROG, 12);
		chk(disp_o.view, VIEW_SETP);
		$display("Test programming done");
		tap(KEY_UP, 12);
		rd(8'h14);
		chk(q, 32'h1f5);
		tap(KEY_DOWN, 960);
		rd(8'h14);
		chk(q < 32'h1f3, 1'b1);
		tap(KEY_FUNC, 12);
		chk(disp_o.view, VIEW_OUTF);
		tap(KEY_UP, 12);
		chk(disp_o.view, VIEW_CUST);
		$display("Test keys and views done");
		go(KEY_INCH, 150);
		cycles(480);
		chk(out_freq_o, 16'h3c);
		for (k = 0; k < 9000 && busy; k++) cycles(1);
		halt();
		wr(8'h00, 32'h1);
		avi <= 16'h64;
		aci <= 16'h32;
		tap(KEY_RUN, 12);
		reach(16'h96);
		tap(KEY_STOP, 12);
		halt();
		$display("Test inch and analog source done");
		for (int i = 0; i < 3; i++) begin
			wr(8'h00, 32'h84 | (i << 5));
			tap(KEY_RUN, 12);
			chk(drive_on_o, 1'b0);
			term_fwd_i <= i > 0;
			term_rev_i <= 1'b1;
			term_stop_i <= 1'b1;
			cycles(100);
			chk(drive_on_o, 1'b1);
			chk(reverse_o, 1'b1);
			term_fwd_i <= 1'b0;
			term_rev_i <= 1'b0;
			term_stop_i <= 1'b0;
			cycles(4);
			chk({drive_on_o, out_freq_o}, 17'h0);
		end
		$display("Test terminal control done");
		fault_i <= 1'b1;
		cycles(3);
		fault_i <= 1'b0;
		tap(KEY_PROG, 12);
		chk(n_fr, 1);
		$display("Test fault clear done");
		end_of_test();
	end
endmodule // drive_keypad_front_panel_control_tb
`default_nettype wire
